// ### lbc_consts.vh
/*
  lbc_consts.vh: offsets, field positions, reset values and timing counts
  for the local bus controller and clock generator.
  assumes: included by bare name from the design file; definitions only.
*/
`ifndef LBC_CONSTS_VH
`define LBC_CONSTS_VH

// window and relocation layout
`define LBC_OFF_RELOC        8'ha8
`define LBC_OFF_PWRCTL       8'hb8
`define LBC_OFF_PWRSAVE      8'hbe
`define LBC_RELOC_RESET      16'h20ff
`define LBC_RELOC_BASE_MSB   11
`define LBC_RELOC_MEMSEL_BIT 12
`define LBC_WIN_OFF_W        8
// power control fields
`define LBC_PWR_IDLE_BIT     0
`define LBC_PWR_DOWN_BIT     1
`define LBC_PSAVE_EN_BIT     15
`define LBC_PSAVE_DIV_MSB    2
`define LBC_PSAVE_DIV_MAX    3'h6
// bus cycle timing
`define LBC_MIN_STATES       4
// status codes, driven during a cycle
`define LBC_STAT_IORD        3'h1
`define LBC_STAT_IOWR        3'h2
`define LBC_STAT_MEMRD       3'h5
`define LBC_STAT_MEMWR       3'h6
`define LBC_STAT_PASSIVE     3'h7

`endif

// ### lbc_local_bus_controller.v
/*
  lbc_local_bus_controller.v: local bus cycle engine, hold handshake,
  transceiver control, peripheral register window decode, relocation and
  power registers, divide-by-two clock generator with low-power modes.
  assumes: sys_clk is the crystal or external input clock (any source);
  the processor core issues requests on the processor clock enable and
  keeps them until reqDone; ready and hold pins are asynchronous.
*/
//
// Overview of operation
// (R1) every bus cycle presents a 20-bit address, one megabyte of reach.
// (R2) each cycle drives read or write strobe and a cycle type status.
// (R3) writes drive data on the bus; reads capture returned bus data.
// (R4) cycles last four states minimum; wait states added while ready low.
// (R5) hold request releases the bus, grant shown on hold acknowledge.
// (R6) two transceiver controls: data enable strobe and direction select.
// (R7) address and data share the same bus lines, multiplexed in time.
// (R8) processor clock runs at half the input clock frequency.
// (R9) one divider makes all phase clocks and the clock output together.
// (R10) clock output has fifty percent duty at processor frequency.
// (R11) crystal or external clock feed the same divider identically.
// (R12) three low-power modes exist besides normal active operation.
// (R13) peripheral registers live in one 128-word sixteen-bit window.
// (R14) window base is any 256-byte boundary, in memory or io space.
// (R15) idle stops the core clock low, bus tick and peripherals keep running.
// (R16) powerdown holds all clocks low and disables the oscillator.
// (R17) powersave slows all clocks by a prescaler, down to one sixty-fourth.
// (R18) hold granted only between cycles; bus resumed after hold drops.
// (R19) window accesses go to the internal bus, not the external pins.
`timescale 1ns/1ps
`default_nettype none
`include "lbc_consts.vh"

module lbc_local_bus_controller #(
  parameter ADDR_W = 20,
  parameter DATA_W = 16
) (
  input  wire              sys_clk,
  input  wire              rst_b,
  input  wire              xtalSelect,
  input  wire              wakeEvent,
  input  wire              reqValid,
  input  wire              reqWrite,
  input  wire              reqIo,
  input  wire [ADDR_W-1:0] reqAddr,
  input  wire [DATA_W-1:0] reqWdata,
  output wire              reqDone,
  output reg  [DATA_W-1:0] reqRdata,
  input  wire [DATA_W-1:0] adIn,
  output reg  [DATA_W-1:0] adOut,
  output reg               adOe,
  output reg  [ADDR_W-1:DATA_W] addrHigh,
  output reg               addrLatch,
  output reg               readStrobeN,
  output reg               writeStrobeN,
  output reg  [2:0]        cycleStatus,
  input  wire              readyIn,
  input  wire              holdRequest,
  output reg               bus_grant_acknowledge,
  output reg               transceiver_data_enable_n,
  output reg               transceiver_direction,
  output reg               processor_clock_out,
  output reg               coreClockEn,
  output reg               periphClockEn,
  output reg               oscEnable,
  output reg               periphSel,
  output reg               periphWrite,
  output reg  [6:0]        periphIndex,
  output reg  [DATA_W-1:0] periphWdata,
  input  wire [DATA_W-1:0] periphRdata
);

  // bus cycle states; ST_INT serves the register window with no strobes, latch, status or bus drive
  localparam ST_IDLE = 3'h0;
  localparam ST_T1   = 3'h1;
  localparam ST_T2   = 3'h2;
  localparam ST_T3   = 3'h3;
  localparam ST_T4   = 3'h4;
  localparam ST_HOLD = 3'h5;
  localparam ST_INT  = 3'h6;

  // register window contents, clock divider state and the captured request
  reg  [2:0]        stateQ;
  reg  [15:0]       relocQ;
  reg  [15:0]       pwrCtlQ;
  reg  [15:0]       pwrSaveQ;
  reg               phaseQ;
  reg  [5:0]        prescQ;
  reg               procTickQ;
  reg  [1:0]        readySyncQ;
  reg  [1:0]        holdSyncQ;
  reg  [1:0]        wakeSyncQ;
  reg               wrQ;
  reg               ioQ;
  reg  [ADDR_W-1:0] addrQ;
  reg  [DATA_W-1:0] wdataQ;
  reg               doneQ;
  wire              readySeen = readySyncQ[1];
  wire              holdSeen  = holdSyncQ[1];
  wire              idleMode  = pwrCtlQ[`LBC_PWR_IDLE_BIT];
  wire              downMode  = pwrCtlQ[`LBC_PWR_DOWN_BIT];
  wire              saveMode  = pwrSaveQ[`LBC_PSAVE_EN_BIT];
  wire [2:0]        saveDiv   = pwrSaveQ[`LBC_PSAVE_DIV_MSB:0];
  wire [5:0]        prescTop;
  wire              inWindow;
  wire              winMemSel = relocQ[`LBC_RELOC_MEMSEL_BIT];

  // prescale limit: 2^div - 1 processor periods, capped at 1/64
  assign prescTop = (saveDiv > `LBC_PSAVE_DIV_MAX) ? 6'h3f :
                    (6'h3f >> (`LBC_PSAVE_DIV_MAX - saveDiv)); // [R17]

  // window hit: top 12 address bits equal base, space matches [R13] [R14]
  assign inWindow = (reqAddr[ADDR_W-1:`LBC_WIN_OFF_W] ==
                     relocQ[`LBC_RELOC_BASE_MSB:0]) && (reqIo != winMemSel);

  assign reqDone = doneQ;

  // xtalSelect is not read: both clock sources reach the divider alike
  // pin synchronisers: first stage read only by the second
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readySyncQ <= 2'h0;
      holdSyncQ  <= 2'h0;
      wakeSyncQ  <= 2'h0;
    end else begin
      readySyncQ <= {readySyncQ[0], readyIn};
      holdSyncQ  <= {holdSyncQ[0], holdRequest};
      wakeSyncQ  <= {wakeSyncQ[0], wakeEvent};
    end
  end

  // divide by two; same path whatever feeds sys_clk [R8] [R11]
  // the tick and clock output come from one phase bit, fixed skew [R9]
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseQ              <= 1'b0;
      prescQ              <= 6'h00;
      procTickQ           <= 1'b0;
      processor_clock_out <= 1'b0;
      coreClockEn         <= 1'b0;
      periphClockEn       <= 1'b0;
      oscEnable           <= 1'b1;
    end else begin
      oscEnable <= ~downMode; // [R16]
      if (downMode) begin
        // everything frozen low [R16]
        phaseQ              <= 1'b0;
        procTickQ           <= 1'b0;
        processor_clock_out <= 1'b0;
        coreClockEn         <= 1'b0;
        periphClockEn       <= 1'b0;
      end else begin
        phaseQ <= ~phaseQ;
        if (phaseQ) begin
          if (!saveMode || prescQ >= prescTop)
            prescQ <= 6'h00;
          else
            prescQ <= prescQ + 6'h01; // [R17]
        end
        // equal high and low halves at the processor rate [R10]
        // in powersave the output stays high for the first half of the
        // prescaled period, so the slowed clock keeps its 50% duty
        // a divide setting of zero leaves the plain half rate in place
        if (!saveMode || prescTop == 6'h00)
          processor_clock_out <= ~phaseQ;
        else
          processor_clock_out <= (prescQ <= {1'b0, prescTop[5:1]});
        procTickQ     <= phaseQ & (~saveMode | (prescQ == prescTop));
        // idle stops the core tick only, bus tick and peripherals continue [R15]
        coreClockEn   <= phaseQ & ~idleMode &
                         (~saveMode | (prescQ == prescTop));
        periphClockEn <= phaseQ & (~saveMode | (prescQ == prescTop));
      end
    end
  end

  // bus cycle engine, advanced once per processor tick [R4]
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ   <= ST_IDLE;
      wrQ      <= 1'b0;
      ioQ      <= 1'b0;
      addrQ    <= {ADDR_W{1'b0}};
      wdataQ   <= {DATA_W{1'b0}};
      doneQ    <= 1'b0;
      reqRdata <= {DATA_W{1'b0}};
      relocQ   <= `LBC_RELOC_RESET;
      pwrCtlQ  <= 16'h0000;
      pwrSaveQ <= 16'h0000;
    end else begin
      doneQ <= 1'b0;
      // a wake event ends idle and powerdown; beats a same-cycle write
      if (wakeSyncQ[1])
        pwrCtlQ <= 16'h0000; // [R12]
      if (procTickQ && !doneQ) begin
        case (stateQ)
          ST_IDLE: begin
            // hold wins over a pending request at the boundary
            if (holdSeen)
              stateQ <= ST_HOLD; // [R18]
            else if (reqValid) begin
              wrQ    <= reqWrite;
              ioQ    <= reqIo;
              addrQ  <= reqAddr; // [R1]
              wdataQ <= reqWdata;
              stateQ <= inWindow ? ST_INT : ST_T1; // [R19]
            end
          end
          ST_T1: stateQ <= ST_T2;
          ST_T2: stateQ <= ST_T3;
          ST_T3: begin
            // read data is taken while the strobe still stands low; once
            // the strobe rises the slave may release the lines at once
            if (readySeen) begin
              if (!wrQ)
                reqRdata <= adIn; // [R3]
              stateQ <= ST_T4;
            end
            // otherwise a wait state, strobe held low [R4]
          end
          ST_T4: begin
            doneQ  <= 1'b1;
            stateQ <= ST_IDLE;
          end
          ST_HOLD: begin
            if (!holdSeen)
              stateQ <= ST_IDLE; // resume after release [R18]
          end
          ST_INT: begin
            // internal window access in one state, no strobes, latch, status or bus drive
            if (wrQ) begin
              case (addrQ[`LBC_WIN_OFF_W-1:0])
                `LBC_OFF_RELOC:   relocQ   <= wdataQ; // [R14]
                `LBC_OFF_PWRCTL:  if (!wakeSyncQ[1]) pwrCtlQ <= wdataQ;
                `LBC_OFF_PWRSAVE: pwrSaveQ <= wdataQ; // [R17]
                default: ;
              endcase
            end else begin
              case (addrQ[`LBC_WIN_OFF_W-1:0])
                `LBC_OFF_RELOC:   reqRdata <= relocQ;
                `LBC_OFF_PWRCTL:  reqRdata <= pwrCtlQ;
                `LBC_OFF_PWRSAVE: reqRdata <= pwrSaveQ;
                default:          reqRdata <= periphRdata;
              endcase
            end
            doneQ  <= 1'b1;
            stateQ <= ST_IDLE;
          end
          default: stateQ <= ST_IDLE;
        endcase
      end
    end
  end

  // pin outputs registered from the state [R2] [R5] [R6] [R7]
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adOut                     <= {DATA_W{1'b0}};
      adOe                      <= 1'b0;
      addrHigh                  <= {(ADDR_W-DATA_W){1'b0}};
      addrLatch                 <= 1'b0;
      readStrobeN               <= 1'b1;
      writeStrobeN              <= 1'b1;
      cycleStatus               <= `LBC_STAT_PASSIVE;
      bus_grant_acknowledge     <= 1'b0;
      transceiver_data_enable_n <= 1'b1;
      transceiver_direction     <= 1'b1;
      periphSel                 <= 1'b0;
      periphWrite               <= 1'b0;
      periphIndex               <= 7'h00;
      periphWdata               <= {DATA_W{1'b0}};
    end else begin
      bus_grant_acknowledge <= (stateQ == ST_HOLD); // [R5]
      addrLatch    <= (stateQ == ST_T1);
      addrHigh     <= addrQ[ADDR_W-1:DATA_W]; // [R1]
      // address phase then data phase on the same lines [R7]
      adOut        <= (stateQ == ST_T1) ? addrQ[DATA_W-1:0] : wdataQ;
      adOe         <= (stateQ == ST_T1) ||
                      (wrQ && (stateQ == ST_T2 || stateQ == ST_T3 ||
                               stateQ == ST_T4)); // [R3]
      readStrobeN  <= ~(!wrQ && (stateQ == ST_T2 || stateQ == ST_T3));
      writeStrobeN <= ~(wrQ && (stateQ == ST_T2 || stateQ == ST_T3));
      if (stateQ == ST_T1 || stateQ == ST_T2 || stateQ == ST_T3)
        cycleStatus <= ioQ ? (wrQ ? `LBC_STAT_IOWR : `LBC_STAT_IORD) :
                       (wrQ ? `LBC_STAT_MEMWR : `LBC_STAT_MEMRD); // [R2]
      else
        cycleStatus <= `LBC_STAT_PASSIVE;
      // buffers on during data phase; direction high means transmit [R6]
      transceiver_data_enable_n <= ~(stateQ == ST_T2 || stateQ == ST_T3 ||
                                     stateQ == ST_T4);
      transceiver_direction     <= (stateQ == ST_IDLE || stateQ == ST_HOLD)
                                   ? 1'b1 : wrQ;
      // internal window strobe, one tick wide [R13] [R19]
      periphSel   <= (stateQ == ST_INT) && procTickQ;
      periphWrite <= wrQ;
      periphIndex <= addrQ[7:1];
      periphWdata <= wdataQ;
    end
  end

endmodule
`default_nettype wire

// ### lbc_memory_model.sv
/* lbc_memory_model.sv: external memory on the multiplexed bus, with
   a programmable number of not-ready cycles per strobe.
   assumes: same clock as the bus controller, 16 words decoded. */
`timescale 1ns/1ps
`default_nettype none
module lbc_memory_model (
  input  wire logic        sys_clk,
  input  wire logic        addrLatch,
  input  wire logic        readStrobeN,
  input  wire logic        writeStrobeN,
  input  wire logic [15:0] adOut,
  input  wire logic [3:0]  waitStates,
  output logic      [15:0] adIn,
  output logic             readyIn
);
  logic [15:0] mem [0:15];
  logic [3:0]  addr_q;
  logic [3:0]  cnt_q = 4'h0;
  logic [15:0] last_q;
  // address comes off the shared lines in the latch phase
  always @(posedge sys_clk) begin
    if (addrLatch) addr_q <= adOut[4:1];
    if (!writeStrobeN) mem[addr_q] <= adOut;
    if (!readStrobeN) last_q <= mem[addr_q];
    cnt_q <= (readStrobeN && writeStrobeN) ? 4'h0 : cnt_q + 4'h1;
  end
  // not ready until the strobe has stood long enough
  assign readyIn = (cnt_q >= waitStates);
  // released bus shows the inverse, never a stale copy
  assign adIn = readStrobeN ? ~last_q : mem[addr_q];
endmodule
`default_nettype wire

// ### lbc_local_bus_controller_asserts.sv
/* lbc_local_bus_controller_asserts.sv: bus cycle and clock checks.
   assumes: bound to lbc_local_bus_controller, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "lbc_consts.vh"
module lbc_local_bus_controller_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       reqDone,
  input wire logic       adOe,
  input wire logic       addrLatch,
  input wire logic       readStrobeN,
  input wire logic       writeStrobeN,
  input wire logic [2:0] cycleStatus,
  input wire logic       readyIn,
  input wire logic       holdRequest,
  input wire logic       bus_grant_acknowledge,
  input wire logic       transceiver_data_enable_n,
  input wire logic       transceiver_direction,
  input wire logic       coreClockEn,
  input wire logic       periphClockEn,
  input wire logic       oscEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // cycle start, and a read held off by the slave
  sequence cycStart; $rose(addrLatch); endsequence
  sequence stalled; (!readStrobeN && !readyIn) [*3]; endsequence

  a_strobe_excl: assert property (readStrobeN || writeStrobeN)
    else $error("both strobes low");
  a_read_status: assert property (!readStrobeN |-> cycleStatus inside
    {`LBC_STAT_IORD, `LBC_STAT_MEMRD} && !adOe && !transceiver_direction
    && !transceiver_data_enable_n)
    else $error("read phase wrong");
  a_write_drive: assert property (!writeStrobeN |-> adOe &&
    transceiver_direction && cycleStatus inside
    {`LBC_STAT_IOWR, `LBC_STAT_MEMWR})
    else $error("write phase wrong");
  a_addr_driven: assert property (addrLatch |-> adOe)
    else $error("address not driven");
  a_min_states: assert property (cycStart |-> !reqDone [*7])
    else $error("cycle too short");
  a_wait_held: assert property (stalled |=> !readStrobeN)
    else $error("ended without ready");
  a_grant_quiet: assert property (bus_grant_acknowledge |->
    !adOe && readStrobeN && writeStrobeN)
    else $error("bus driven in hold");
  a_grant_boundary: assert property ($rose(bus_grant_acknowledge) |->
    $past(readStrobeN) && $past(writeStrobeN) && !$past(addrLatch))
    else $error("grant inside a cycle");
  a_hold_resume: assert property ($fell(holdRequest) |->
    ##[1:12] !bus_grant_acknowledge)
    else $error("grant kept");
  a_clock_subset: assert property (coreClockEn |-> periphClockEn)
    else $error("core tick alone");
  a_down_frozen: assert property (!oscEnable |->
    !coreClockEn && !periphClockEn)
    else $error("tick in powerdown");
endmodule
`default_nettype wire
bind lbc_local_bus_controller lbc_local_bus_controller_asserts i_chk (
  .sys_clk, .rst_b, .reqDone, .adOe, .addrLatch, .readStrobeN,
  .writeStrobeN, .cycleStatus, .readyIn, .holdRequest,
  .bus_grant_acknowledge, .transceiver_data_enable_n,
  .transceiver_direction, .coreClockEn, .periphClockEn, .oscEnable);

// ### lbc_local_bus_controller_bench.sv
/* lbc_local_bus_controller_bench.sv: self-checking bench.
   assumes: memory model on the bus, window reset base 0x0ff00 io space. */
`timescale 1ns/1ps
`default_nettype none
module lbc_local_bus_controller_bench;
  logic sys_clk = 0, rst_b = 0, xtalSelect = 0, wakeEvent = 0;
  logic reqValid = 0, reqWrite = 0, reqIo = 0, holdRequest = 0;
  logic [19:0] reqAddr = 20'h0, seenAddr;
  logic [15:0] reqWdata = 16'h0, reqRdata, adIn, adOut, periphWdata, rd;
  logic [3:0] addrHigh, waitStates = 4'h0;
  logic [2:0] cycleStatus;
  logic [6:0] periphIndex;
  logic reqDone, adOe, addrLatch, readStrobeN, writeStrobeN, readyIn;
  logic bus_grant_acknowledge, transceiver_data_enable_n, sawLatch;
  logic transceiver_direction, processor_clock_out, coreClockEn;
  logic periphClockEn, oscEnable, periphSel, periphWrite;
  int fails = 0, n_compared = 0, dur, nCore, nPer, nRise, nHigh;

  lbc_local_bus_controller i_dut (.sys_clk, .rst_b, .xtalSelect,
    .wakeEvent, .reqValid, .reqWrite, .reqIo, .reqAddr, .reqWdata,
    .reqDone, .reqRdata, .adIn, .adOut, .adOe, .addrHigh, .addrLatch,
    .readStrobeN, .writeStrobeN, .cycleStatus, .readyIn, .holdRequest,
    .bus_grant_acknowledge, .transceiver_data_enable_n,
    .transceiver_direction, .processor_clock_out, .coreClockEn,
    .periphClockEn, .oscEnable, .periphSel, .periphWrite, .periphIndex,
    .periphWdata, .periphRdata(16'h5a0f));
  lbc_memory_model i_mem (.sys_clk, .addrLatch, .readStrobeN,
    .writeStrobeN, .adOut, .waitStates, .adIn, .readyIn);

  // 25 MHz input clock
  always #20 sys_clk = ~sys_clk;

  task automatic cmp(input string what, input logic [19:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request, held until done; records the address phase
  task automatic access(input logic wr, io, input logic [19:0] a,
                        input logic [15:0] wd);
    int n;
    sawLatch = 0;
    @(posedge sys_clk) #1;
    {reqValid, reqWrite, reqIo, reqAddr, reqWdata} = {1'b1, wr, io, a, wd};
    for (n = 0; n < 300; n++) begin
      @(posedge sys_clk) #1;
      if (addrLatch === 1'b1 && !sawLatch) begin
        sawLatch = 1;
        seenAddr = {addrHigh, adOut};
      end
      if (reqDone === 1'b1) break;
    end
    cmp("done", 1, reqDone);
    rd = reqRdata;
    dur = n;
    reqValid = 0;
  endtask
  // counts ticks and clock output edges over n cycles
  task automatic count(input int n);
    logic prev;
    {nCore, nPer, nRise, nHigh} = 0;
    prev = processor_clock_out;
    repeat (n) begin
      @(posedge sys_clk) #1;
      nCore += coreClockEn;
      nPer += periphClockEn;
      nHigh += processor_clock_out;
      nRise += (processor_clock_out && !prev);
      prev = processor_clock_out;
    end
  endtask
  task automatic t_bus;
    int base;
    for (int io = 0; io < 2; io++) begin
      access(1, io[0], io ? 20'h00016 : 20'hf0010, 16'ha55a ^ io[15:0]);
      cmp("addr", io ? 20'h00016 : 20'hf0010, seenAddr);
      access(0, io[0], io ? 20'h00016 : 20'hf0010, 16'h0);
      cmp("rdata", 16'ha55a ^ io[15:0], rd);
    end
    base = dur;
    waitStates = 4'ha;
    access(0, 0, 20'hf0010, 16'h0);
    waitStates = 4'h0;
    cmp("rdata", 16'ha55a, rd);
    cmp("waited", 1, dur >= base + 8);
  endtask
  task automatic t_hold;
    @(posedge sys_clk) #1 holdRequest = 1;
    for (int n = 0; n < 30 && bus_grant_acknowledge !== 1'b1; n++)
      @(posedge sys_clk) #1;
    cmp("grant", 1, bus_grant_acknowledge);
    cmp("bus off", 0, adOe);
    holdRequest = 0;
    repeat (20) @(posedge sys_clk) #1;
    cmp("grant", 0, bus_grant_acknowledge);
    access(0, 1, 20'h00016, 16'h0);
    cmp("rdata", 16'ha55b, rd);
  endtask
  task automatic t_window;
    access(0, 1, 20'h0ffa8, 16'h0);
    cmp("reloc", 16'h20ff, rd);
    cmp("latch", 0, sawLatch);
    // move the window to 0x012xx in memory space
    access(1, 1, 20'h0ffa8, 16'h1012);
    access(0, 0, 20'h012a8, 16'h0);
    cmp("reloc", 16'h1012, rd);
    cmp("latch", 0, sawLatch);
    access(0, 1, 20'h0ffa8, 16'h0);
    cmp("latch", 1, sawLatch);
    // a peripheral register, served over the internal strobe
    access(0, 0, 20'h012a0, 16'h0);
    cmp("periph rd", 16'h5a0f, rd);
    cmp("periph sel", 1, periphSel);
    cmp("periph index", 7'h50, periphIndex);
    access(1, 0, 20'h012a8, 16'h20ff);
  endtask
  task automatic wake;
    @(posedge sys_clk) #1 wakeEvent = 1;
    repeat (4) @(posedge sys_clk);
    #1 wakeEvent = 0;
    repeat (4) @(posedge sys_clk) #1;
  endtask
  task automatic t_power;
    access(1, 1, 20'h0ffb8, 16'h0001);
    count(20);
    cmp("core", 0, nCore);
    cmp("periph", 10, nPer);
    wake();
    access(1, 1, 20'h0ffb8, 16'h0002);
    count(20);
    cmp("osc", 0, oscEnable);
    cmp("periph", 0, nPer);
    wake();
    cmp("osc", 1, oscEnable);
  endtask
  task automatic t_clock;
    for (int xs = 0; xs < 2; xs++) begin
      xtalSelect = xs[0];
      count(40);
      cmp("rises", 20, nRise);
      cmp("high", 20, nHigh);
      cmp("core", 20, nCore);
    end
    access(1, 1, 20'h0ffbe, 16'h8001);
    count(128);
    cmp("slowed", 1, nPer >= 31 && nPer <= 33);
    cmp("high", 64, nHigh);
    access(1, 1, 20'h0ffbe, 16'h0000);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence after an eight cycle reset
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1;
    t_bus();
    t_hold();
    t_window();
    t_power();
    t_clock();
    report_and_stop();
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
